// >>> core/mcuex_pkg.sv
// Purpose: shared constants and types of the instruction execute slice
// Assumes: one instruction issued per clock from the fetch side
// Notes: opcode codes are an internal encoding, not the program word format
package mcuex_pkg;

   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int PC_W = 13;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 13'h0000;
   localparam logic IRQ_EN_RST = 1'b0;
   localparam logic EXPIRY_N_RST = 1'b1;
   localparam logic SLEPT_N_RST = 1'b1;

   // ************************************************************
   // field encodings and timing
   // ************************************************************
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam int RETURN_CYCLES = 2;

   typedef enum logic [3:0] {
      op_nop = 4'h0,
      op_or_literal_into_acc = 4'h1,
      op_load_literal = 4'h2,
      op_or_acc_with_file = 4'h3,
      op_store_acc_to_file = 4'h4,
      op_copy_file = 4'h5,
      op_return_from_irq = 4'h6,
      op_rotate_left_via_spill = 4'h7,
      op_rotate_right_via_spill = 4'h8,
      op_return_with_literal = 4'h9,
      op_return = 4'hA,
      op_sleep = 4'hB,
      op_literal_minus_acc = 4'hC,
      op_xor_literal_into_acc = 4'hD
   } mcuex_op_t;

   typedef struct packed {
      mcuex_op_t op;
      logic [DATA_W-1:0] lit;
      logic [FADDR_W-1:0] faddr;
      logic dest;
   } mcuex_instr_t;

   typedef struct packed {
      logic c;
      logic nibble_spill_bit;
      logic z;
   } mcuex_flags_t;

   localparam mcuex_flags_t FLAGS_RST = 3'h0;

   typedef enum logic [2:0] {
      st_run = 3'h1,
      st_second = 3'h2,
      st_sleep = 3'h4
   } mcuex_state_t;

endpackage

// >>> core/mcuex_core.sv
// Purpose: executes logic, move, subtract, rotate, return and sleep instructions
// Assumes: file read data for the issued address is valid in the issue cycle
// Notes: a return spends one extra cycle; sleep is left only by reset
`timescale 1ns/1ps
`default_nettype none
module mcuex_core
   import mcuex_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // instruction issue
   input wire logic i_issue,
   input wire mcuex_instr_t i_instr,
   input wire logic [DATA_W-1:0] i_file_rdata,
   input wire logic [PC_W-1:0] i_stack_head,
   // working state
   output logic [DATA_W-1:0] o_acc,
   output mcuex_flags_t o_flags,
   output logic o_global_irq_enable,
   // program counter and stack
   output logic [PC_W-1:0] o_pc,
   output logic o_pc_load,
   output logic o_stack_pop,
   // file register write
   output logic o_file_we,
   output logic [FADDR_W-1:0] o_file_addr,
   output logic [DATA_W-1:0] o_file_wdata,
   // power, watchdog and return stall
   output logic o_wdt_clear,
   output logic o_watchdog_expiry_flag_n,
   output logic o_sleep_entered_flag_n,
   output logic o_stall,
   output logic o_sleep
);

   // ************************************************************
   // state
   // ************************************************************
   logic [DATA_W-1:0] acc_reg, acc_next;
   mcuex_flags_t flags_reg, flags_next;
   logic irq_en_reg, irq_en_next;
   logic [PC_W-1:0] pc_reg, pc_next;
   logic pc_load_reg, pc_load_next;
   logic pop_reg, pop_next;
   logic fwe_reg, fwe_next;
   logic [FADDR_W-1:0] faddr_reg, faddr_next;
   logic [DATA_W-1:0] fwdata_reg, fwdata_next;
   logic wdt_clr_reg, wdt_clr_next;
   logic expiry_n_reg, expiry_n_next;
   logic slept_n_reg, slept_n_next;
   mcuex_state_t state_reg, state_next;
   logic [DATA_W-1:0] result;
   logic write_result, take;
   logic [DATA_W:0] diff;
   logic [4:0] diff_lo;

   // an instruction is only taken in the running state
   assign take = i_issue && (state_reg == st_run);

   // ************************************************************
   // execute: next values
   // ************************************************************
   always_comb begin
      acc_next = acc_reg;
      flags_next = flags_reg;
      irq_en_next = irq_en_reg;
      pc_next = pc_reg;
      pc_load_next = 1'b0;
      pop_next = 1'b0;
      fwe_next = 1'b0;
      faddr_next = faddr_reg;
      fwdata_next = fwdata_reg;
      wdt_clr_next = 1'b0;
      expiry_n_next = expiry_n_reg;
      slept_n_next = slept_n_reg;
      state_next = state_reg;
      result = ZERO_BYTE;
      write_result = 1'b0;
      // two's complement subtract: literal plus inverted accumulator plus one
      diff = {1'b0, i_instr.lit} + {1'b0, ~acc_reg} + 9'h001;
      diff_lo = {1'b0, i_instr.lit[3:0]} + {1'b0, ~acc_reg[3:0]} + 5'h01;
      case (state_reg)
         st_run: begin
            if (i_issue) begin
               case (i_instr.op)
                  op_or_literal_into_acc: begin
                     acc_next = acc_reg | i_instr.lit;
                     flags_next.z = ((acc_reg | i_instr.lit) == ZERO_BYTE);
                  end
                  op_load_literal: begin
                     acc_next = i_instr.lit;
                  end
                  op_or_acc_with_file: begin
                     result = acc_reg | i_file_rdata;
                     write_result = 1'b1;
                     flags_next.z = (result == ZERO_BYTE);
                  end
                  op_store_acc_to_file: begin
                     fwe_next = 1'b1;
                     faddr_next = i_instr.faddr;
                     fwdata_next = acc_reg;
                  end
                  op_copy_file: begin
                     result = i_file_rdata;
                     write_result = 1'b1;
                     flags_next.z = (result == ZERO_BYTE);
                  end
                  op_rotate_left_via_spill: begin
                     result = {i_file_rdata[DATA_W-2:0], flags_reg.c};
                     flags_next.c = i_file_rdata[DATA_W-1];
                     write_result = 1'b1;
                  end
                  op_rotate_right_via_spill: begin
                     result = {flags_reg.c, i_file_rdata[DATA_W-1:1]};
                     flags_next.c = i_file_rdata[0];
                     write_result = 1'b1;
                  end
                  op_return_from_irq, op_return_with_literal, op_return: begin
                     pc_next = i_stack_head;
                     pc_load_next = 1'b1;
                     pop_next = 1'b1;
                     state_next = st_second;
                     irq_en_next = irq_en_reg | (i_instr.op == op_return_from_irq);
                     acc_next = (i_instr.op == op_return_with_literal) ? i_instr.lit : acc_reg;
                  end
                  op_sleep: begin
                     wdt_clr_next = 1'b1;
                     expiry_n_next = 1'b1;
                     slept_n_next = 1'b0;
                     state_next = st_sleep;
                  end
                  op_literal_minus_acc: begin
                     acc_next = diff[DATA_W-1:0];
                     flags_next.c = diff[DATA_W];
                     flags_next.nibble_spill_bit = diff_lo[4];
                     flags_next.z = (diff[DATA_W-1:0] == ZERO_BYTE);
                  end
                  op_xor_literal_into_acc: begin
                     acc_next = acc_reg ^ i_instr.lit;
                     flags_next.z = ((acc_reg ^ i_instr.lit) == ZERO_BYTE);
                  end
                  default: begin
                     acc_next = acc_reg;
                  end
               endcase
               // destination routing of file-register results
               if (write_result) begin
                  if (i_instr.dest == DEST_ACC) begin
                     acc_next = result;
                  end else begin
                     fwe_next = 1'b1;
                     faddr_next = i_instr.faddr;
                     fwdata_next = result;
                  end
               end
            end
         end
         st_second: begin
            state_next = st_run;
         end
         st_sleep: begin
            state_next = st_sleep;
         end
         default: begin
            state_next = st_run;
         end
      endcase
   end

   // ************************************************************
   // execute: registers
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         acc_reg <= ACC_RST;
         flags_reg <= FLAGS_RST;
         irq_en_reg <= IRQ_EN_RST;
         pc_reg <= PC_RST;
         pc_load_reg <= 1'b0;
         pop_reg <= 1'b0;
         fwe_reg <= 1'b0;
         faddr_reg <= 7'h00;
         fwdata_reg <= ZERO_BYTE;
         wdt_clr_reg <= 1'b0;
         expiry_n_reg <= EXPIRY_N_RST;
         slept_n_reg <= SLEPT_N_RST;
         state_reg <= st_run;
      end else begin
         acc_reg <= acc_next;
         flags_reg <= flags_next;
         irq_en_reg <= irq_en_next;
         pc_reg <= pc_next;
         pc_load_reg <= pc_load_next;
         pop_reg <= pop_next;
         fwe_reg <= fwe_next;
         faddr_reg <= faddr_next;
         fwdata_reg <= fwdata_next;
         wdt_clr_reg <= wdt_clr_next;
         expiry_n_reg <= expiry_n_next;
         slept_n_reg <= slept_n_next;
         state_reg <= state_next;
      end
   end

   // outputs straight from the registers
   assign o_acc = acc_reg;
   assign o_flags = flags_reg;
   assign o_global_irq_enable = irq_en_reg;
   assign o_pc = pc_reg;
   assign o_pc_load = pc_load_reg;
   assign o_stack_pop = pop_reg;
   assign o_file_we = fwe_reg;
   assign o_file_addr = faddr_reg;
   assign o_file_wdata = fwdata_reg;
   assign o_wdt_clear = wdt_clr_reg;
   assign o_watchdog_expiry_flag_n = expiry_n_reg;
   assign o_sleep_entered_flag_n = slept_n_reg;
   assign o_stall = state_reg[1];
   assign o_sleep = state_reg[2];

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   or_literal_a: assert property (take && i_instr.op == op_or_literal_into_acc |=>
      o_acc == ($past(acc_reg) | $past(i_instr.lit)) && o_flags.c == $past(flags_reg.c)
      && o_flags.nibble_spill_bit == $past(flags_reg.nibble_spill_bit))
      else $error("or literal result or flags wrong");
   load_literal_a: assert property (take && i_instr.op == op_load_literal |=>
      o_acc == $past(i_instr.lit) && $stable(o_flags))
      else $error("load literal wrong");
   or_file_a: assert property (take && i_instr.op == op_or_acc_with_file && i_instr.dest == DEST_FILE |=>
      o_file_we && o_file_wdata == ($past(acc_reg) | $past(i_file_rdata)) && $stable(o_acc))
      else $error("or with file wrong");
   dest_acc_a: assert property (take && i_instr.op == op_copy_file && i_instr.dest == DEST_ACC |=>
      !o_file_we && o_acc == $past(i_file_rdata))
      else $error("copy to accumulator wrong");
   store_acc_a: assert property (take && i_instr.op == op_store_acc_to_file |=>
      o_file_we && o_file_addr == $past(i_instr.faddr) && o_file_wdata == $past(acc_reg) && $stable(o_flags))
      else $error("store accumulator wrong");
   copy_zero_a: assert property (take && i_instr.op == op_copy_file |=>
      o_flags.z == ($past(i_file_rdata) == ZERO_BYTE))
      else $error("copy zero flag wrong");
   irq_return_a: assert property (take && i_instr.op == op_return_from_irq |=>
      o_pc_load && o_pc == $past(i_stack_head) && o_global_irq_enable)
      else $error("irq return wrong");
   rotate_left_a: assert property (take && i_instr.op == op_rotate_left_via_spill && i_instr.dest == DEST_ACC |=>
      o_acc == {$past(i_file_rdata[6:0]), $past(flags_reg.c)} && o_flags.c == $past(i_file_rdata[7]))
      else $error("rotate left wrong");
   rotate_right_a: assert property (take && i_instr.op == op_rotate_right_via_spill && i_instr.dest == DEST_ACC |=>
      o_acc == {$past(flags_reg.c), $past(i_file_rdata[7:1])} && o_flags.c == $past(i_file_rdata[0]))
      else $error("rotate right wrong");
   literal_return_a: assert property (take && i_instr.op == op_return_with_literal |=>
      o_acc == $past(i_instr.lit) && o_stall && $stable(o_flags) ##1 !o_stall)
      else $error("literal return wrong");
   sub_return_a: assert property (take && i_instr.op == op_return |=>
      o_stack_pop && o_pc == $past(i_stack_head) && o_stall ##1 !o_stall && !o_stack_pop)
      else $error("subroutine return wrong");
   sleep_status_a: assert property (take && i_instr.op == op_sleep |=>
      o_wdt_clear && o_watchdog_expiry_flag_n && !o_sleep_entered_flag_n)
      else $error("sleep status wrong");
   sleep_hold_a: assert property (take && i_instr.op == op_sleep |=> o_sleep [*4])
      else $error("sleep not held");
   subtract_a: assert property (take && i_instr.op == op_literal_minus_acc |=>
      o_acc == 8'($past(i_instr.lit) - $past(acc_reg)) && o_flags.c == ($past(i_instr.lit) >= $past(acc_reg))
      && o_flags.nibble_spill_bit == ($past(i_instr.lit[3:0]) >= $past(acc_reg[3:0])))
      else $error("literal subtract wrong");
   xor_literal_a: assert property (take && i_instr.op == op_xor_literal_into_acc |=>
      o_acc == ($past(acc_reg) ^ $past(i_instr.lit)) && o_flags.c == $past(flags_reg.c))
      else $error("xor literal wrong");
   zero_flag_a: assert property (take && i_instr.op == op_literal_minus_acc |=>
      o_flags.z == (o_acc == ZERO_BYTE))
      else $error("zero flag wrong");
   sleep_c: cover property (take && i_instr.op == op_sleep ##1 o_sleep);
   return_c: cover property (take && i_instr.op == op_return ##1 o_stall ##1 !o_stall);
   borrow_c: cover property (take && i_instr.op == op_literal_minus_acc ##1 !o_flags.c);
   rotate_c: cover property (take && i_instr.op == op_rotate_left_via_spill && i_instr.dest == DEST_FILE);
endmodule
`default_nettype wire

// >>> verification/test_mcu_core_instruction_execute.sv
// Purpose: self-checking bench for the instruction execute slice
// Assumes: one instruction issued at a time, effects checked 1 ns after the taking edge
// Notes: sleep is left only by reset, so the sleep test ends with a second reset
`timescale 1ns/1ps
`default_nettype none
module test_mcu_core_instruction_execute;
   import mcuex_pkg::*;

   // ************************************************************
   // clock, reset and design signals
   // ************************************************************
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_issue = 1'b0;
   mcuex_instr_t i_instr = '0;
   logic [DATA_W-1:0] i_file_rdata = 8'h00;
   logic [PC_W-1:0] i_stack_head = 13'h0000;
   logic [DATA_W-1:0] o_acc;
   mcuex_flags_t o_flags;
   logic o_global_irq_enable;
   logic [PC_W-1:0] o_pc;
   logic o_pc_load;
   logic o_stack_pop;
   logic o_file_we;
   logic [FADDR_W-1:0] o_file_addr;
   logic [DATA_W-1:0] o_file_wdata;
   logic o_wdt_clear;
   logic o_watchdog_expiry_flag_n;
   logic o_sleep_entered_flag_n;
   logic o_stall;
   logic o_sleep;
   int miscompares = 0;
   int num_checks = 0;

   // 250 MHz clock
   always #2 i_clk = ~i_clk;

   mcuex_core u_mcuex_core (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_issue(i_issue), .i_instr(i_instr),
      .i_file_rdata(i_file_rdata), .i_stack_head(i_stack_head), .o_acc(o_acc), .o_flags(o_flags),
      .o_global_irq_enable(o_global_irq_enable), .o_pc(o_pc), .o_pc_load(o_pc_load),
      .o_stack_pop(o_stack_pop), .o_file_we(o_file_we), .o_file_addr(o_file_addr),
      .o_file_wdata(o_file_wdata), .o_wdt_clear(o_wdt_clear),
      .o_watchdog_expiry_flag_n(o_watchdog_expiry_flag_n),
      .o_sleep_entered_flag_n(o_sleep_entered_flag_n), .o_stall(o_stall), .o_sleep(o_sleep)
   );

   // ************************************************************
   // shared tasks
   // ************************************************************
   // compare with case equality and count
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // present one instruction, let it be taken, settle; hold keeps a load pending in the next cycle
   task automatic run_op(input mcuex_op_t op, input logic [7:0] lit, input logic [6:0] fa,
                         input logic d, input logic [7:0] rdata, input logic [12:0] head,
                         input logic hold = 1'b0);
      @(posedge i_clk);
      i_issue <= 1'b1;
      i_instr <= '{op: op, lit: lit, faddr: fa, dest: d};
      i_file_rdata <= rdata;
      i_stack_head <= head;
      @(posedge i_clk);
      if (hold) begin
         i_instr <= '{op: op_load_literal, lit: 8'h11, faddr: 7'h00, dest: 1'b0};
      end else begin
         i_issue <= 1'b0;
      end
      #1;
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   // reset values after release
   task automatic t_reset;
      check("acc", o_acc, 8'h00);
      check("flags", o_flags, 3'h0);
      check("irq enable", o_global_irq_enable, 1'h0);
      check("expiry_n slept_n sleep", {o_watchdog_expiry_flag_n, o_sleep_entered_flag_n, o_sleep}, 3'h6);
      $display("test reset done");
   endtask

   // literal loads, ors and xors with zero flag
   task automatic t_literals;
      run_op(op_load_literal, 8'h5A, 7'h00, 1'b0, 8'h00, 13'h0000);
      check("acc", {o_flags, o_acc}, 11'h05A);
      run_op(op_or_literal_into_acc, 8'h00, 7'h00, 1'b0, 8'h00, 13'h0000);
      check("acc", {o_flags, o_acc}, 11'h05A);
      run_op(op_nop, 8'hFF, 7'h00, 1'b1, 8'hFF, 13'h0000);
      check("nop", {o_flags, o_acc, o_file_we}, 12'h0B4);
      run_op(op_xor_literal_into_acc, 8'h5A, 7'h00, 1'b0, 8'h00, 13'h0000);
      check("acc", {o_flags, o_acc}, 11'h100);
      run_op(op_or_literal_into_acc, 8'h81, 7'h00, 1'b0, 8'h00, 13'h0000);
      check("acc", {o_flags, o_acc}, 11'h081);
      run_op(op_load_literal, 8'h00, 7'h00, 1'b0, 8'h00, 13'h0000);
      check("acc", {o_flags, o_acc}, 11'h000);
      run_op(op_or_literal_into_acc, 8'h00, 7'h00, 1'b0, 8'h00, 13'h0000);
      check("acc", {o_flags, o_acc}, 11'h100);
      run_op(op_xor_literal_into_acc, 8'hFF, 7'h00, 1'b0, 8'h00, 13'h0000);
      check("acc", {o_flags, o_acc}, 11'h0FF);
      $display("test literals done");
   endtask

   // file operations and destination routing
   task automatic t_file;
      run_op(op_load_literal, 8'h0F, 7'h00, 1'b0, 8'h00, 13'h0000);
      run_op(op_or_acc_with_file, 8'h00, 7'h7F, 1'b1, 8'h30, 13'h0000);
      check("or to file", {o_file_we, o_file_addr, o_file_wdata, o_acc}, 24'hFF3F0F);
      check("flags", o_flags, 3'h0);
      run_op(op_or_acc_with_file, 8'h00, 7'h01, 1'b0, 8'h30, 13'h0000);
      check("or to acc", {o_file_we, o_acc}, 9'h03F);
      run_op(op_load_literal, 8'h00, 7'h00, 1'b0, 8'h00, 13'h0000);
      run_op(op_or_acc_with_file, 8'h00, 7'h01, 1'b0, 8'h00, 13'h0000);
      check("or zero", {o_flags, o_acc}, 11'h100);
      run_op(op_load_literal, 8'h3C, 7'h00, 1'b0, 8'h00, 13'h0000);
      run_op(op_store_acc_to_file, 8'h00, 7'h2A, 1'b0, 8'h99, 13'h0000);
      check("store", {o_file_we, o_file_addr, o_file_wdata, o_flags}, 19'h551E1);
      run_op(op_copy_file, 8'h00, 7'h11, 1'b1, 8'h00, 13'h0000);
      check("copy to file", {o_file_we, o_file_addr, o_file_wdata, o_flags}, 19'h48801);
      run_op(op_copy_file, 8'h00, 7'h11, 1'b0, 8'h80, 13'h0000);
      check("copy to acc", {o_file_we, o_flags, o_acc}, 12'h080);
      $display("test file done");
   endtask

   // literal minus accumulator with carry, nibble and zero
   task automatic t_sub;
      run_op(op_load_literal, 8'h05, 7'h00, 1'b0, 8'h00, 13'h0000);
      run_op(op_literal_minus_acc, 8'h03, 7'h00, 1'b0, 8'h00, 13'h0000);
      check("sub borrow", {o_flags, o_acc}, 11'h0FE);
      run_op(op_load_literal, 8'h13, 7'h00, 1'b0, 8'h00, 13'h0000);
      run_op(op_literal_minus_acc, 8'h23, 7'h00, 1'b0, 8'h00, 13'h0000);
      check("sub carry", {o_flags, o_acc}, 11'h610);
      run_op(op_load_literal, 8'h10, 7'h00, 1'b0, 8'h00, 13'h0000);
      run_op(op_literal_minus_acc, 8'h10, 7'h00, 1'b0, 8'h00, 13'h0000);
      check("sub zero", {o_flags, o_acc}, 11'h700);
      $display("test subtract done");
   endtask

   // rotations through carry, starting with carry set
   task automatic t_rotate;
      run_op(op_rotate_left_via_spill, 8'h00, 7'h05, 1'b0, 8'h80, 13'h0000);
      check("rl acc", {o_file_we, o_flags, o_acc}, 12'h701);
      run_op(op_rotate_left_via_spill, 8'h00, 7'h06, 1'b1, 8'h01, 13'h0000);
      check("rl file", {o_file_we, o_file_addr, o_file_wdata, o_flags}, 19'h4301B);
      run_op(op_rotate_right_via_spill, 8'h00, 7'h07, 1'b0, 8'h01, 13'h0000);
      check("rr acc", {o_file_we, o_flags, o_acc}, 12'h700);
      run_op(op_rotate_right_via_spill, 8'h00, 7'h55, 1'b1, 8'h02, 13'h0000);
      check("rr file", {o_file_we, o_file_addr, o_file_wdata, o_flags}, 19'h6AC0B);
      $display("test rotate done");
   endtask

   // returns, with an issue refused during the second cycle
   task automatic t_returns;
      run_op(op_return_with_literal, 8'hA5, 7'h00, 1'b0, 8'h00, 13'h1ABC, 1'b1);
      check("literal return", {o_acc, o_pc, o_pc_load, o_stack_pop, o_stall}, 24'hA5D5E7);
      check("flags", o_flags, 3'h3);
      @(posedge i_clk);
      i_issue <= 1'b0;
      #1;
      check("second cycle", {o_acc, o_pc_load, o_stack_pop, o_stall}, 11'h528);
      run_op(op_return, 8'h77, 7'h00, 1'b0, 8'h00, 13'h0123);
      check("return", {o_acc, o_pc, o_pc_load, o_stack_pop, o_flags}, 26'h294247B);
      run_op(op_return_from_irq, 8'h00, 7'h00, 1'b0, 8'h00, 13'h1001);
      check("irq return", {o_global_irq_enable, o_pc, o_pc_load}, 15'h6003);
      $display("test returns done");
   endtask

   // sleep side effects, halt, then a second reset
   task automatic t_sleep;
      run_op(op_sleep, 8'h00, 7'h00, 1'b0, 8'h00, 13'h0000, 1'b1);
      check("sleep", {o_wdt_clear, o_watchdog_expiry_flag_n, o_sleep_entered_flag_n, o_sleep}, 4'hD);
      @(posedge i_clk);
      i_issue <= 1'b0;
      #1;
      check("asleep", {o_wdt_clear, o_sleep, o_acc}, 10'h1A5);
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      #1;
      check("woken", {o_sleep, o_sleep_entered_flag_n, o_acc}, 10'h100);
      $display("test sleep done");
   endtask

   // ************************************************************
   // main sequence and watchdog
   // ************************************************************
   initial begin
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      #1;
      t_reset();
      t_literals();
      t_file();
      t_sub();
      t_rotate();
      t_returns();
      t_sleep();
      report_and_stop();
   end

   // cut a hang short well beyond the 75 or so cycles the tests need
   initial begin
      repeat (3000) @(posedge i_clk);
      miscompares++;
      report_and_stop();
   end
endmodule
`default_nettype wire
